// ### pwmtb_pkg.sv
/*
  Package for the PWM master time base: register map, field layout,
  reset values and the bus carrier types.
  Assumes an AXI4-Lite register bus with 32-bit data.
*/
package pwmtb_pkg;

  // Register byte offsets
  localparam logic [3:0] PRESCALE_OFFSET = 4'h0;
  localparam logic [3:0] PERIOD_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // Field positions
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_WIDTH = 3;
  localparam int ENABLE_BIT = 0;
  localparam int COUNTER_LSB = 16;

  // Reset values and the reserved prescale code
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [15:0] PERIOD_RESET = 16'hFFF8;
  localparam logic [2:0] PRESCALE_RESERVED = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pwmtb_wreq_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } pwmtb_rresp_t;

endpackage : pwmtb_pkg

// ### pwmtb_prescaler.sv
/*
  Power-of-two prescaler producing a one-cycle tick per divided period.
  Assumes select changes only while the counter is disabled.
*/
`timescale 1ns/1ps
module pwmtb_prescaler #(
  parameter int SEL_WIDTH = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Control
  input wire logic run_i,
  input wire logic [SEL_WIDTH-1:0] sel_i,
  // Tick
  output logic tick_o
);

  localparam int CW = (1 << SEL_WIDTH) - 1;

  // Mask arithmetic is 64 bits wide, so the divider tops out at 63 bits
  if (SEL_WIDTH < 1 || SEL_WIDTH > 6) begin : g_sel_width_check
    $error("pwmtb_prescaler: SEL_WIDTH must be 1 to 6");
  end

  logic [CW-1:0] div_reg;
  logic [CW-1:0] div_next;
  logic tick_next;
  logic [CW-1:0] mask;

  always_comb begin
    mask = CW'((64'h1 << sel_i) - 64'h1);
    div_next = div_reg;
    tick_next = 1'b0;
    if (!run_i) begin
      div_next = '0;
    end else if ((div_reg & mask) == mask) begin
      div_next = '0;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_reg <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      div_reg <= div_next;
      tick_o <= tick_next;
    end
  end

endmodule : pwmtb_prescaler

// ### pwmtb_top.sv
/*
  PWM master time base: prescale select and period registers over
  AXI4-Lite, a prescaler and the 16-bit master time-base counter.
  Assumes one clock (the PWM input clock) and a well-behaved AXI master.
*/
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - Prescale select bits 2:0 divide by 1..64; code 7 reserved.
// RULE_02 - Prescale select resets to code 0, no division.
// RULE_03 - Software changes prescale select only while module enable is clear.
// RULE_04 - Prescale register bits 15:3 ignore writes and read zero.
// RULE_05 - Sixteen-bit read/write period register sets the counter period.
// RULE_06 - Software loads period only from 0x0010 to 0xFFF8.
// RULE_07 - Counter advances per prescaled tick, restarts from zero after period.
module pwmtb_top #(
  parameter int CNT_WIDTH = 16
) (
  // Clock, enable, reset
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic reset_n_i,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Time base outputs
  output logic [CNT_WIDTH-1:0] master_time_base_counter_o,
  output logic period_end_o
);

  // Counter, period register and read mux are all sized for 16 bits;
  // refuse other widths at elaboration rather than truncate silently
  if (CNT_WIDTH != 16) begin : g_cnt_width_check
    $error("pwmtb_top: CNT_WIDTH must be 16");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register and bus state

  logic [2:0] presc_reg, presc_next;
  logic [15:0] period_reg, period_next;
  logic enable_reg, enable_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  pwmtb_pkg::pwmtb_wreq_t wreq_reg, wreq_next;
  logic bvalid_next;
  logic [1:0] bresp_next;
  logic rvalid_next;
  pwmtb_pkg::pwmtb_rresp_t rd_reg, rd_next;
  logic awready_next, wready_next, arready_next;
  logic [CNT_WIDTH-1:0] cnt_reg, cnt_next;
  logic pend_next;
  logic tick;

  always_comb begin
    presc_next = presc_reg;
    period_next = period_reg;
    enable_next = enable_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    wreq_next = wreq_reg;
    bvalid_next = s_axi_bvalid_o;
    bresp_next = s_axi_bresp_o;
    rvalid_next = s_axi_rvalid_o;
    rd_next = rd_reg;
    // Write channels taken independently, one write in flight
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got_next = 1'b1;
      wreq_next.addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got_next = 1'b1;
      wreq_next.data = s_axi_wdata_i;
      wreq_next.strb = s_axi_wstrb_i;
    end
    if (aw_got_reg && w_got_reg && !s_axi_bvalid_o) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = pwmtb_pkg::RESP_OKAY;
      unique case (wreq_reg.addr)
        pwmtb_pkg::PRESCALE_OFFSET: begin
          // Upper bits have no storage, reserved code kept out
          if (wreq_reg.strb[0] && wreq_reg.data[2:0] != pwmtb_pkg::PRESCALE_RESERVED) begin
            presc_next = wreq_reg.data[pwmtb_pkg::PRESCALE_LSB +: 3]; // see RULE_01 see RULE_04
          end
        end
        pwmtb_pkg::PERIOD_OFFSET: begin
          if (wreq_reg.strb[0]) period_next[7:0] = wreq_reg.data[7:0]; // see RULE_05
          if (wreq_reg.strb[1]) period_next[15:8] = wreq_reg.data[15:8]; // see RULE_05
        end
        pwmtb_pkg::STATUS_OFFSET: begin
          if (wreq_reg.strb[0]) enable_next = wreq_reg.data[pwmtb_pkg::ENABLE_BIT];
        end
        default: bresp_next = pwmtb_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rd_next.resp = pwmtb_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i)
        pwmtb_pkg::PRESCALE_OFFSET: rd_next.data = {29'h0, presc_reg}; // see RULE_04
        pwmtb_pkg::PERIOD_OFFSET: rd_next.data = {16'h0, period_reg}; // see RULE_05
        pwmtb_pkg::STATUS_OFFSET: rd_next.data = {cnt_reg, 15'h0, enable_reg};
        default: begin
          rd_next.data = 32'h0;
          rd_next.resp = pwmtb_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_reg <= pwmtb_pkg::PRESCALE_RESET; // see RULE_02
      period_reg <= pwmtb_pkg::PERIOD_RESET;
      enable_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wreq_reg <= '0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= pwmtb_pkg::RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      rd_reg <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end else if (ce_i) begin
      presc_reg <= presc_next;
      period_reg <= period_next;
      enable_reg <= enable_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      wreq_reg <= wreq_next;
      s_axi_bvalid_o <= bvalid_next;
      s_axi_bresp_o <= bresp_next;
      s_axi_rvalid_o <= rvalid_next;
      rd_reg <= rd_next;
      s_axi_awready_o <= awready_next;
      s_axi_wready_o <= wready_next;
      s_axi_arready_o <= arready_next;
    end
  end

  assign s_axi_rdata_o = rd_reg.data;
  assign s_axi_rresp_o = rd_reg.resp;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and master counter

  // Divider restarts whenever the module is disabled, so a select
  // change made while stopped takes effect cleanly
  pwmtb_prescaler #(
    .SEL_WIDTH(pwmtb_pkg::PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .run_i(enable_reg), // see RULE_03
    .sel_i(presc_reg), // see RULE_01
    .tick_o(tick)
  );

  always_comb begin
    cnt_next = cnt_reg;
    pend_next = 1'b0;
    if (!enable_reg) begin
      cnt_next = '0;
    end else if (tick) begin
      // Period values below range still wrap; software keeps them out
      if (cnt_reg >= period_reg) begin // see RULE_07 see RULE_06
        cnt_next = '0;
        pend_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_WIDTH'(1); // see RULE_07
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
      period_end_o <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      period_end_o <= pend_next;
    end
  end

  assign master_time_base_counter_o = cnt_reg;

endmodule : pwmtb_top

// ### pwmtb_sva.sv
/* Checker for the PWM master time base: bus answers and counter wrap.
   Assumes it is bound to pwmtb_top, one clock domain. */
`timescale 1ns/1ps
module pwmtb_sva #(
  parameter int CNT_WIDTH = 16
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [CNT_WIDTH-1:0] master_time_base_counter_o,
  input wire logic period_end_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence ar_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence r_waiting;
    s_axi_rvalid_o && !s_axi_rready_i;
  endsequence
  AST_RD_ANSWER: assert property (ar_taken |=> s_axi_rvalid_o)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (r_waiting |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  AST_WR_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write answer dropped");
  AST_WRAP_ZERO: assert property (period_end_o |-> master_time_base_counter_o == '0)
    else $error("wrap not to zero");
  AST_PULSE_ONE: assert property (period_end_o |=> !period_end_o)
    else $error("period pulse too long");
  // Any move other than one to zero (wrap or disable) must be a single step
  AST_STEP: assert property ($changed(master_time_base_counter_o) && master_time_base_counter_o != '0
    |-> master_time_base_counter_o == $past(master_time_base_counter_o) + 1'h1)
    else $error("counter skipped");
endmodule : pwmtb_sva
////////////////////////////////////////////////////////////////////////////////
bind pwmtb_top pwmtb_sva #(.CNT_WIDTH(CNT_WIDTH)) pwmtb_sva_i (
  .clk_i, .reset_n_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .master_time_base_counter_o, .period_end_o
);

// ### tb.sv
/* Testbench for the PWM master time base over AXI4-Lite.
   Assumes the offsets and response codes of pwmtb_pkg. */
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] PRE = pwmtb_pkg::PRESCALE_OFFSET;
  localparam logic [3:0] PER = pwmtb_pkg::PERIOD_OFFSET;
  localparam logic [3:0] CTL = pwmtb_pkg::STATUS_OFFSET;
  localparam logic [1:0] OK = pwmtb_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pwmtb_pkg::RESP_SLVERR;
  logic clk_i = 1'h0;
  logic ce_i = 1'h1;
  logic reset_n_i = 1'h0;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, mx;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, period_end_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [15:0] master_time_base_counter_o;
  int n_fail = 0;
  int n_checks = 0;
  int n;
  always #20 clk_i = ~clk_i;
  pwmtb_top pwmtb_top_i (
    .clk_i, .ce_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .master_time_base_counter_o, .period_end_o
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    // Pre-edge values are read here, so each flag marks a real handshake
    while (!(ad && dd)) begin
      @(posedge clk_i);
      if (s_axi_awready_o) ad = 1'h1;
      if (s_axi_wready_o) dd = 1'h1;
      s_axi_awvalid_i <= !ad;
      s_axi_wvalid_i <= !dd;
    end
    // Late bready makes the slave hold its answer for a cycle
    while (!s_axi_bvalid_o) @(posedge clk_i);
    s_axi_bready_i <= 1'h1;
    @(posedge clk_i);
    while (!s_axi_bvalid_o) @(posedge clk_i);
    s_axi_bready_i <= 1'h0;
    chk({30'h0, s_axi_bresp_o}, {30'h0, er});
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    @(posedge clk_i);
    while (!s_axi_arready_o) @(posedge clk_i);
    s_axi_arvalid_i <= 1'h0;
    // Late rready makes the slave hold read data for a cycle
    @(posedge clk_i);
    s_axi_rready_i <= 1'h1;
    @(posedge clk_i);
    while (!s_axi_rvalid_o) @(posedge clk_i);
    s_axi_rready_i <= 1'h0;
    chk(s_axi_rdata_o, ed);
    chk({30'h0, s_axi_rresp_o}, {30'h0, er});
  endtask : rchk
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rchk(PRE, 32'h0, OK);
    rchk(PER, 32'h0000FFF8, OK);
    rchk(CTL, 32'h0, OK);
    wr(PRE, 32'hFFFFFFFE, OK);
    rchk(PRE, 32'h6, OK);
    wr(PRE, 32'h7, OK);
    rchk(PRE, 32'h6, OK);
    wr(PER, 32'hFFFFA5A5, OK);
    rchk(PER, 32'h0000A5A5, OK);
    wr(4'hC, 32'h1, ERR);
    rchk(4'hC, 32'h0, ERR);
    wr(PER, 32'h10, OK);
    for (int c = 0; c < 7; c++) begin
      wr(CTL, 32'h0, OK);
      wr(PRE, 32'(c), OK);
      wr(CTL, 32'h1, OK);
      @(negedge clk_i);
      while (!period_end_o) @(negedge clk_i);
      n = 0;
      mx = 32'h0;
      do begin
        @(negedge clk_i);
        n++;
        if ({16'h0, master_time_base_counter_o} > mx) mx = {16'h0, master_time_base_counter_o};
      end while (!period_end_o);
      chk(n, 32'h11 << c);
      chk(mx, 32'h10);
    end
    // Clock enable low must freeze the counter; 70 cycles spans a tick
    @(posedge clk_i);
    ce_i <= 1'h0;
    @(posedge clk_i);
    mx = {16'h0, master_time_base_counter_o};
    repeat (70) @(posedge clk_i);
    chk({16'h0, master_time_base_counter_o}, mx);
    ce_i <= 1'h1;
    wr(CTL, 32'h0, OK);
    rchk(CTL, 32'h0, OK);
    conclude();
  end
endmodule : tb
